// *** hdl/cpu_bus_ctrl.sv ***
/*
  Bus interface and control of an 8-bit processor: multiplexed bus,
  strobes, status, wait, hold, general interrupt and reset output.
  Software issues machine cycles over Avalon-MM; pins are split in/out/oe.
*/
// The Avalon-MM slave port and the address map are this design's own decisions.
// Function
// - Interrupt request sampled at instruction end or in halt
// - Accepted interrupt holds PC, issues acknowledge
// - Interrupt enable by software, cleared on accept
// - Acknowledge strobe replaces read on next fetch
// - Low address in T1, data in T2/T3
// - Upper lines carry high address or port
// - Buses and strobes float in halt and from second T of hold
// - Status codes: halt, write, read, fetch
// - Upper status bit is early read flag
// - Address strobe pulses in T1, latch falling
// - No address strobe in bus-idle cycles
// - Address strobe also qualifies status, select
// - Write strobe low while write data driven
// - Read strobe requests data from party
// - Select shows memory or I/O space
// - Ready low inserts wait states
// - Reset zeroes PC, clears enable, hold ack
// - Reset leaves address, write and read data untouched
// - Hold taken after cycle, buses released
// - Buses resume half T after acknowledge falls
// - Hold, ready, interrupt synchronised first
// - Reset output synchronous to clock
`timescale 1ns/1ps
module cpu_bus_ctrl
  import biu_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] addr_data_lo_i,
  output logic [7:0] addr_data_lo_o,
  output logic addr_data_lo_oe,
  output logic [7:0] addr_hi,
  output logic addr_hi_oe,
  output logic bus_stat_hi,
  output logic bus_stat_lo,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic mem_io_sel,
  output logic strobe_oe,
  output logic irq_ack_strobe_n,
  input wire logic ready_in,
  input wire logic hold_req,
  output logic hold_ack,
  input wire logic general_irq_in,
  output logic reset_out
);
  typedef struct packed {
    state_t st;
    logic ph;
    logic hfirst;
    kind_t kind;
    logic last;
    logic busy;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [15:0] program_counter;
    logic [7:0] instr;
    logic ie;
    logic ackm;
    logic taken;
    logic av_wait;
    logic [31:0] av_rdata;
    logic [7:0] ad_o;
    logic ad_oe;
    logic [7:0] ahi;
    logic bus_oe;
    logic ale;
    logic [1:0] stat;
    logic io_m;
    logic rd_n;
    logic wr_n;
    logic irq_ack_strobe_n_n;
    logic holda;
    logic rst_out;
  } biu_t;
  biu_t st_q, st_d;

  logic [2:0] syn;
  logic hold_s, rdy_s, irq_s;
  logic tick, accept, act, xf, mid;
  logic [15:0] a16;

  // Synchronise external requests
  in_sync #(.W(3)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d_in({hold_req, ready_in, general_irq_in}),
    .q_out(syn)
  );
  assign {hold_s, rdy_s, irq_s} = syn;

  // Kind decoding
  function automatic logic is_rd(input kind_t k);
    return k inside {K_FETCH, K_MEM_RD, K_IO_RD};
  endfunction

  function automatic logic is_wr(input kind_t k);
    return k inside {K_MEM_WR, K_IO_WR};
  endfunction

  function automatic logic is_io(input kind_t k);
    return k inside {K_IO_RD, K_IO_WR};
  endfunction

  function automatic logic [1:0] stat_of(input kind_t k);
    logic [1:0] r;
    r = STAT_READ;
    if (k == K_FETCH) r = STAT_FETCH;
    else if (is_wr(k)) r = STAT_WRITE;
    return r;
  endfunction

  // Register read mux
  function automatic logic [31:0] rd_reg(input logic [4:0] a,
                                         input biu_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_CMD: begin
        r[CMD_KIND_LSB +: 3] = s.kind;
        r[CMD_LAST_BIT] = s.last;
      end
      OFS_ADDR: r[15:0] = s.addr;
      OFS_WDATA: r[7:0] = s.wdata;
      OFS_STAT: begin
        r[ST_BUSY] = s.busy;
        r[ST_HOLDA] = s.holda;
        r[ST_HALT] = (s.st == S_HALT);
        r[ST_TAKEN] = s.taken;
        r[ST_ACKM] = s.ackm;
        r[ST_RDATA_LSB +: 8] = s.rdata;
        r[ST_INSTR_LSB +: 8] = s.instr;
      end
      OFS_IE: r[0] = s.ie;
      OFS_PC: r[15:0] = s.program_counter;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Register port, sequencer and pin outputs
  always_comb begin
    st_d = st_q;
    accept = 1'b0;
    tick = st_q.ph;
    st_d.ph = ~st_q.ph;
    st_d.rst_out = 1'b0;
    // Slave: waitrequest drops one cycle after a request
    st_d.av_wait = 1'b1;
    if ((avs_read || avs_write) && st_q.av_wait) begin
      st_d.av_wait = 1'b0;
      if (avs_read) st_d.av_rdata = rd_reg(avs_address, st_q);
    end
    if (avs_write && !st_q.av_wait && avs_byteenable[0]) begin
      case (avs_address)
        OFS_CMD: begin
          if (!st_q.busy && avs_writedata[2:0] <= 3'(K_DAD)) begin
            st_d.kind = kind_t'(avs_writedata[CMD_KIND_LSB +: 3]);
            st_d.last = avs_writedata[CMD_LAST_BIT];
            st_d.busy = 1'b1;
          end
        end
        OFS_ADDR: begin
          st_d.addr[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) st_d.addr[15:8] = avs_writedata[15:8];
        end
        OFS_WDATA: st_d.wdata = avs_writedata[7:0];
        OFS_STAT: if (avs_writedata[ST_TAKEN]) st_d.taken = 1'b0;
        OFS_IE: st_d.ie = avs_writedata[0];
        OFS_PC: begin
          st_d.program_counter[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) begin
            st_d.program_counter[15:8] = avs_writedata[15:8];
          end
        end
        default: ;
      endcase
    end
    // Sequencer, one T-state per two clocks
    unique case (st_q.st)
      S_IDLE: if (tick) begin
        if (hold_s) begin
          st_d.st = S_HOLD;
          st_d.hfirst = 1'b1;
        end else if (st_q.busy) begin
          if (st_q.kind == K_HALT) begin
            st_d.st = S_HALT;
            st_d.busy = 1'b0;
          end else begin
            st_d.st = S_T1;
          end
        end
      end
      S_T1: if (tick) st_d.st = S_T2;
      S_T2: if (tick) begin
        // Ready checked at the end of T2
        if (st_q.kind != K_DAD && !rdy_s) st_d.st = S_TW;
        else st_d.st = S_T3;
      end
      S_TW: if (tick && rdy_s) st_d.st = S_T3;
      S_T3: if (tick) begin
        st_d.busy = 1'b0;
        if (is_rd(st_q.kind)) st_d.rdata = addr_data_lo_i;
        if (st_q.kind == K_FETCH) begin
          st_d.instr = addr_data_lo_i;
          if (!st_q.ackm) begin
            st_d.program_counter = st_q.program_counter + 16'h0001;
          end
        end
        if (st_q.last) begin
          st_d.ackm = 1'b0;
          accept = irq_s && st_q.ie;
        end
        if (hold_s) begin
          st_d.st = S_HOLD;
          st_d.hfirst = 1'b1;
        end else begin
          st_d.st = S_IDLE;
        end
      end
      S_HOLD: if (tick) begin
        st_d.hfirst = 1'b0;
        if (!hold_s && !st_q.hfirst) st_d.st = S_RESUME;
      end
      S_RESUME: if (!tick) st_d.st = S_IDLE;
      S_HALT: if (tick) begin
        if (hold_s) begin
          st_d.st = S_HOLD;
          st_d.hfirst = 1'b1;
        end else if (irq_s && st_q.ie) begin
          accept = 1'b1;
          st_d.st = S_IDLE;
        end else if (st_q.busy) begin
          st_d.st = S_IDLE;
        end
      end
    endcase
    // Accepting disables and arms the acknowledge fetch
    if (accept) begin
      st_d.ie = 1'b0;
      st_d.ackm = 1'b1;
      st_d.taken = 1'b1;
    end
    // Pin values for the coming cycle
    act = st_d.st inside {S_T1, S_T2, S_TW, S_T3};
    xf = act && st_d.kind != K_DAD;
    mid = st_d.st inside {S_T2, S_TW, S_T3};
    a16 = (st_d.kind == K_FETCH) ? st_d.program_counter : st_d.addr;
    st_d.holda = (st_d.st == S_HOLD);
    st_d.bus_oe = !(st_d.st inside {S_HALT, S_RESUME} ||
                    (st_d.st == S_HOLD && !st_d.hfirst));
    st_d.ale = xf && st_d.st == S_T1 && !st_d.ph;
    if (st_d.st == S_HALT) st_d.stat = STAT_HALT;
    else if (act) st_d.stat = stat_of(st_d.kind);
    if (act) st_d.io_m = is_io(st_d.kind);
    st_d.ahi = is_io(st_d.kind) ? a16[7:0] : a16[15:8];
    st_d.ad_o = (st_d.st == S_T1) ? a16[7:0] : st_d.wdata;
    st_d.ad_oe = st_d.bus_oe && xf &&
                 (st_d.st == S_T1 || is_wr(st_d.kind));
    st_d.rd_n = !(xf && mid && is_rd(st_d.kind) &&
                  !(st_d.kind == K_FETCH && st_d.ackm));
    st_d.irq_ack_strobe_n_n = !(xf && mid && st_d.kind == K_FETCH &&
                    st_d.ackm);
    st_d.wr_n = !(xf && mid && is_wr(st_d.kind));
  end

  // State register; address, write and read data registers keep their value over reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.st <= S_IDLE;
      st_q.ph <= 1'b0;
      st_q.hfirst <= 1'b0;
      st_q.kind <= K_FETCH;
      st_q.last <= 1'b0;
      st_q.busy <= 1'b0;
      st_q.program_counter <= PC_RST;
      st_q.instr <= INSTR_RST;
      st_q.ie <= IE_RST;
      st_q.ackm <= 1'b0;
      st_q.taken <= 1'b0;
      st_q.av_wait <= 1'b1;
      st_q.av_rdata <= 32'h0000_0000;
      st_q.ad_o <= 8'h00;
      st_q.ad_oe <= 1'b0;
      st_q.ahi <= 8'h00;
      st_q.bus_oe <= 1'b1;
      st_q.ale <= 1'b0;
      st_q.stat <= STAT_HALT;
      st_q.io_m <= 1'b0;
      st_q.rd_n <= 1'b1;
      st_q.wr_n <= 1'b1;
      st_q.irq_ack_strobe_n_n <= 1'b1;
      st_q.holda <= 1'b0;
      st_q.rst_out <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata = st_q.av_rdata;
  assign avs_waitrequest = st_q.av_wait;
  assign addr_data_lo_o = st_q.ad_o;
  assign addr_data_lo_oe = st_q.ad_oe;
  assign addr_hi = st_q.ahi;
  assign addr_hi_oe = st_q.bus_oe;
  assign strobe_oe = st_q.bus_oe;
  assign {bus_stat_hi, bus_stat_lo} = st_q.stat;
  assign ale = st_q.ale;
  assign rd_n = st_q.rd_n;
  assign wr_n = st_q.wr_n;
  assign mem_io_sel = st_q.io_m;
  assign irq_ack_strobe_n = st_q.irq_ack_strobe_n_n;
  assign hold_ack = st_q.holda;
  assign reset_out = st_q.rst_out;

  // Checks on the bus sequence
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  ale_pulse_a: assert property (ale |=> !ale && $stable(addr_data_lo_o)
    && addr_data_lo_oe) else $error("ale pulse or address bad");
  ale_idle_a: assert property (st_q.kind == K_DAD || !st_q.bus_oe
    |-> !ale) else $error("ale in idle cycle");
  float_a: assert property (st_q.st == S_HALT |-> !addr_hi_oe
    && !addr_data_lo_oe && !strobe_oe) else $error("bus not floated");
  halt_code_a: assert property (st_q.st == S_HALT |-> bus_stat_hi == 1'b0
    && bus_stat_lo == 1'b0) else $error("halt code wrong");
  dad_read_a: assert property (st_q.kind == K_DAD && st_q.st == S_T2
    |-> st_q.stat == STAT_READ && rd_n) else $error("dad status");
  early_rw_a: assert property ((!wr_n |-> !bus_stat_hi) and
    (!rd_n |-> bus_stat_hi)) else $error("early rw bit wrong");
  irq_ack_strobe_n_sub_a: assert property (!irq_ack_strobe_n |-> rd_n && wr_n
    && st_q.ackm) else $error("ack strobe with read");
  ie_clear_a: assert property (accept |=> !st_q.ie && st_q.ackm)
    else $error("enable not cleared");
  wait_ins_a: assert property (st_q.st == S_T2 && tick && !rdy_s
    && st_q.kind != K_DAD |=> st_q.st == S_TW [*2])
    else $error("wait state missing");
  hold_rel_a: assert property ($rose(hold_ack) |-> strobe_oe ##2
    !strobe_oe) else $error("hold release timing");
  resume_a: assert property ($fell(hold_ack) |-> !strobe_oe ##1
    strobe_oe) else $error("resume timing");
  io_port_a: assert property (ale && mem_io_sel |-> addr_hi ==
    addr_data_lo_o) else $error("port address mismatch");
  pc_hold_a: assert property (!irq_ack_strobe_n ##1 irq_ack_strobe_n
    |-> $stable(st_q.program_counter)) else $error("pc moved");

  hold_c: cover property ($rose(hold_ack) ##[1:40] $fell(hold_ack));
  wait_c: cover property (st_q.st == S_TW ##1 st_q.st == S_TW);
  irq_ack_strobe_n_c: cover property ($fell(irq_ack_strobe_n));
  dad_c: cover property (st_q.kind == K_DAD && st_q.st == S_T3);
endmodule

// *** hdl/in_sync.sv ***
/*
  Two-flop synchroniser for a group of level inputs.
  Assumes inputs may change at any time relative to clk.
*/
`timescale 1ns/1ps
module in_sync #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t sy_q, sy_d;

  // First stage feeds only the second
  always_comb begin
    sy_d.s1 = d_in;
    sy_d.s2 = sy_q.s1;
  end

  // Both stages
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign q_out = sy_q.s2;
endmodule

// *** inc/biu_pkg.sv ***
/*
  Shared constants and types of the processor bus interface block.
  Assumes a single 125 MHz clock and a 32-bit Avalon-MM register port.
*/
package biu_pkg;
  // Register byte offsets
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_WDATA = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_IE = 5'h10;
  localparam logic [4:0] OFS_PC = 5'h14;
  // Command register fields
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_LAST_BIT = 3;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_HOLDA = 1;
  localparam int ST_HALT = 2;
  localparam int ST_TAKEN = 3;
  localparam int ST_ACKM = 4;
  localparam int ST_RDATA_LSB = 8;
  localparam int ST_INSTR_LSB = 16;
  // Bus status codes, upper bit first
  localparam logic [1:0] STAT_HALT = 2'h0;
  localparam logic [1:0] STAT_WRITE = 2'h1;
  localparam logic [1:0] STAT_READ = 2'h2;
  localparam logic [1:0] STAT_FETCH = 2'h3;
  // Values after reset
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] INSTR_RST = 8'h00;
  localparam logic IE_RST = 1'b0;
  // Clocks per T-state: the phase bit splits each T-state in two
  localparam int T_STATE_CLKS = 2;
  // Machine cycle kinds as written to the command register
  typedef enum logic [2:0] {
    K_FETCH, K_MEM_RD, K_MEM_WR, K_IO_RD, K_IO_WR, K_HALT, K_DAD
  } kind_t;
  // Bus sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_T1, S_T2, S_TW, S_T3, S_HOLD, S_RESUME, S_HALT
  } state_t;
endpackage

// *** tb/bus_partner.sv ***
/*
  Memory and port model on the far side of the processor bus.
  Assumes the bench sets the wait length and the acknowledge opcode.
*/
`timescale 1ns/1ps
module bus_partner (
  input wire logic clk,
  input wire logic [7:0] ad_o,
  input wire logic ad_oe,
  input wire logic [7:0] a_hi,
  input wire logic [1:0] st,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic io,
  input wire logic s_oe,
  input wire logic ack_n,
  input wire logic [7:0] n_wait,
  input wire logic [7:0] ack_op,
  output logic [7:0] ad_i,
  output logic ready,
  output logic [15:0] l_addr,
  output logic [1:0] l_st,
  output logic l_io,
  output logic [1:0] seen_st,
  output logic [7:0] wbyte,
  output int n_ale,
  output int n_ack,
  output int s_len
);
  logic [7:0] mem [0:65535];
  logic [7:0] ports [0:255];
  logic [7:0] last = 8'h00;
  logic pend = 1'b0;
  int cnt = 0;
  int wcnt = 0;
  wire rd = (s_oe && !rd_n) || !ack_n;
  wire strb = rd || (s_oe && !wr_n);
  initial begin
    n_ale = 0;
    n_ack = 0;
    s_len = 0;
  end
  // Resolve the shared lines; released lines show a changing pattern
  always @* begin
    if (ad_oe) ad_i = ad_o;
    else if (!ack_n) ad_i = ack_op;
    else if (rd) ad_i = l_io ? ports[l_addr[7:0]] : mem[l_addr];
    else ad_i = ~last;
  end
  // Slow party drops ready from the address strobe for n_wait clocks,
  // early enough to clear the two-flop input synchroniser before T2 ends
  assign ready = !pend;
  // Latch on the address strobe, store writes, measure strobes
  always @(posedge clk) begin
    last <= ad_i;
    cnt <= strb ? cnt + 1 : 0;
    // Wait window opened by the address strobe
    if (ale && n_wait != 8'h00) begin
      pend <= 1'b1;
      wcnt <= 1;
    end else if (pend) begin
      if (wcnt >= n_wait) pend <= 1'b0;
      wcnt <= wcnt + 1;
    end
    if (!strb && cnt > 0) s_len <= cnt;
    if (ale) begin
      l_addr <= {a_hi, ad_o};
      l_st <= st;
      l_io <= io;
      n_ale <= n_ale + 1;
    end
    if (st != 2'h0) seen_st <= st;
    if (!ack_n && cnt == 0) n_ack <= n_ack + 1;
    if (s_oe && !wr_n) begin
      wbyte <= ad_o;
      if (l_io) ports[l_addr[7:0]] <= ad_o;
      else mem[l_addr] <= ad_o;
    end
  end
endmodule

// *** tb/cpu_bus_interface_control_tb.sv ***
/*
  Self-checking bench of the processor bus interface block.
  Assumes a 125 MHz clock and the bus partner model on the far side.
*/
`timescale 1ns/1ps
module cpu_bus_interface_control_tb;
  import biu_pkg::*;
  typedef struct {
    kind_t kind;
    logic [15:0] addr;
    logic [7:0] wd;
    logic [7:0] exp;
    logic [1:0] st;
    logic io;
  } row_t;
  row_t rows [6] = '{
    '{K_MEM_WR, 16'h1234, 8'h5A, 8'h5A, STAT_WRITE, 1'b0},
    '{K_MEM_RD, 16'h1234, 8'h00, 8'h5A, STAT_READ, 1'b0},
    '{K_IO_WR, 16'h4040, 8'h33, 8'h33, STAT_WRITE, 1'b1},
    '{K_IO_RD, 16'h4040, 8'h00, 8'h33, STAT_READ, 1'b1},
    '{K_MEM_WR, 16'h0000, 8'hC3, 8'hC3, STAT_WRITE, 1'b0},
    '{K_FETCH, 16'h0000, 8'h00, 8'hC3, STAT_FETCH, 1'b0}};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, st, q, pcv;
  logic [7:0] addr_data_lo_i, addr_data_lo_o, addr_hi, wbyte, g;
  logic [7:0] n_wait = 8'h00;
  logic [15:0] l_addr;
  logic [1:0] l_st, seen_st;
  logic avs_waitrequest, addr_data_lo_oe, addr_hi_oe, bus_stat_hi, l_io;
  logic bus_stat_lo, ale, rd_n, wr_n, mem_io_sel, strobe_oe, reset_out;
  logic irq_ack_strobe_n, ready_in, hold_ack;
  logic hold_req = 1'b0;
  logic general_irq_in = 1'b0;
  int n_ale, n_ack, s_len, na;
  int n_fail = 0;
  int checked = 0;
  initial forever #4 clk = ~clk;
  cpu_bus_ctrl cpu_bus_ctrl_i (.clk, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .addr_data_lo_i, .addr_data_lo_o, .addr_data_lo_oe,
    .addr_hi, .addr_hi_oe, .bus_stat_hi, .bus_stat_lo, .ale, .rd_n, .wr_n,
    .mem_io_sel, .strobe_oe, .irq_ack_strobe_n, .ready_in, .hold_req,
    .hold_ack, .general_irq_in, .reset_out);
  bus_partner bus_partner_i (.clk, .ad_o(addr_data_lo_o),
    .ad_oe(addr_data_lo_oe), .a_hi(addr_hi), .st({bus_stat_hi, bus_stat_lo}),
    .ale, .rd_n, .wr_n, .io(mem_io_sel), .s_oe(strobe_oe),
    .ack_n(irq_ack_strobe_n), .n_wait, .ack_op(8'hCF), .ad_i(addr_data_lo_i),
    .ready(ready_in), .l_addr, .l_st, .l_io, .seen_st, .wbyte, .n_ale,
    .n_ack, .s_len);
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] v);
    checked++;
    if (v !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      conclude();
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] r);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    tmo(k, 20);
    @(posedge clk);
  endtask
  task automatic rr(input logic [4:0] a, output logic [31:0] r);
    av(1'b0, a, 32'h0, 4'hF, r);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    av(1'b1, a, d, 4'hF, r);
  endtask
  // Issue one machine cycle and poll a status bit
  task automatic run(input logic [3:0] c, input logic [15:0] a,
    input logic [7:0] d, input int b, input logic v);
    int k;
    k = 0;
    wr(OFS_ADDR, {16'h0000, a});
    wr(OFS_WDATA, {24'h000000, d});
    wr(OFS_CMD, {28'h0000000, c});
    rr(OFS_STAT, st);
    while (st[b] !== v && k < 100) begin
      rr(OFS_STAT, st);
      k++;
    end
    tmo(k, 100);
  endtask
  task automatic wsig(ref logic s, input logic v);
    int k;
    k = 0;
    @(posedge clk);
    while (s !== v && k < 50) begin
      @(posedge clk);
      k++;
    end
    tmo(k, 50);
  endtask
  // Main sequence: table, then hand-written awkward cases
  initial begin
    repeat (6) @(posedge clk);
    cmp("rst_out", 1'b1, reset_out);
    cmp("hold_ack", 1'b0, hold_ack);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("rst_out", 1'b0, reset_out);
    rr(OFS_PC, q);
    cmp("pc", PC_RST, q[15:0]);
    rr(OFS_IE, q);
    cmp("ie", IE_RST, q[0]);
    foreach (rows[i]) begin
      run({1'b0, rows[i].kind}, rows[i].addr, rows[i].wd, ST_BUSY, 1'b0);
      g = rows[i].kind == K_FETCH ? st[ST_INSTR_LSB +: 8] :
        rows[i].st == STAT_WRITE ? wbyte : st[ST_RDATA_LSB +: 8];
      cmp("data", rows[i].exp, g);
      cmp("addr", rows[i].addr, l_addr);
      cmp("status", rows[i].st, l_st);
      cmp("io", rows[i].io, l_io);
      cmp("strobe_len", 4, s_len);
    end
    rr(OFS_PC, q);
    cmp("pc", 16'h0001, q[15:0]);
    na = n_ale;
    run(4'h6, 16'h0000, 8'h00, ST_BUSY, 1'b0);
    cmp("dad_status", STAT_READ, seen_st);
    cmp("dad_ale", na, n_ale);
    n_wait <= 8'h06;
    run(4'h1, 16'h1234, 8'h00, ST_BUSY, 1'b0);
    cmp("wait_data", 8'h5A, st[ST_RDATA_LSB +: 8]);
    cmp("wait_len", 1'b1, s_len > 4);
    n_wait <= 8'h00;
    wr(OFS_IE, 32'h1);
    general_irq_in <= 1'b1;
    run(4'h0, 16'h0000, 8'h00, ST_BUSY, 1'b0);
    cmp("taken", 1'b0, st[ST_TAKEN]);
    run(4'h8, 16'h0000, 8'h00, ST_BUSY, 1'b0);
    cmp("taken", 1'b1, st[ST_TAKEN]);
    cmp("ack_mode", 1'b1, st[ST_ACKM]);
    general_irq_in <= 1'b0;
    rr(OFS_IE, q);
    cmp("ie", 1'b0, q[0]);
    rr(OFS_PC, pcv);
    na = n_ack;
    run(4'h8, 16'h0000, 8'h00, ST_BUSY, 1'b0);
    cmp("ack_op", 8'hCF, st[ST_INSTR_LSB +: 8]);
    cmp("acks", na + 1, n_ack);
    rr(OFS_PC, q);
    cmp("pc_held", pcv[15:0], q[15:0]);
    hold_req <= 1'b1;
    wsig(hold_ack, 1'b1);
    repeat (2) @(posedge clk);
    cmp("float", 3'h0, {strobe_oe, addr_hi_oe, addr_data_lo_oe});
    rr(OFS_STAT, q);
    cmp("st_holda", 1'b1, q[ST_HOLDA]);
    hold_req <= 1'b0;
    wsig(hold_ack, 1'b0);
    @(posedge clk);
    cmp("resume", 2'h3, {strobe_oe, addr_hi_oe});
    run(4'h5, 16'h0000, 8'h00, ST_HALT, 1'b1);
    @(posedge clk);
    cmp("halt_float", 3'h0, {strobe_oe, addr_hi_oe, addr_data_lo_oe});
    cmp("halt_st", STAT_HALT, {bus_stat_hi, bus_stat_lo});
    run(4'h1, 16'h1234, 8'h00, ST_BUSY, 1'b0);
    cmp("wake_data", 8'h5A, st[ST_RDATA_LSB +: 8]);
    wr(OFS_IE, 32'h1);
    av(1'b1, OFS_IE, 32'h0, 4'h0, q);
    rr(OFS_IE, q);
    cmp("ie_no_lane", 1'b1, q[0]);
    rr(5'h1C, q);
    cmp("unmapped", 32'h0, q);
    wr(OFS_IE, 32'h1);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rr(OFS_PC, q);
    cmp("pc", PC_RST, q[15:0]);
    rr(OFS_IE, q);
    cmp("ie", IE_RST, q[0]);
    rr(OFS_STAT, q);
    cmp("kept_byte", 8'h5A, q[ST_RDATA_LSB +: 8]);
    conclude();
  end
endmodule
